// ===== include/mav_pkg.sv
// Shared constants and types for the algorithm variable readback bank
package mav_pkg;
    // Bus and bank geometry
    localparam int AW = 16;
    localparam int DW = 32;
    localparam int IDXW = 12;
    localparam int NREG = 36;
    localparam int NARROW_W = 16;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 13;

    // Register indices; byte address is four times the index
    localparam logic [IDXW-1:0] REG_IDX [NREG] = '{
        12'h190, 12'h196, 12'h410, 12'h440, 12'h442, 12'h444,
        12'h468, 12'h472, 12'h476, 12'h47A, 12'h47C, 12'h47E,
        12'h4B6, 12'h4B8, 12'h4D2, 12'h4D4, 12'h4D6, 12'h4D8,
        12'h4E2, 12'h4E4, 12'h4E6, 12'h4E8, 12'h524, 12'h53C,
        12'h54C, 12'h5D4, 12'h606, 12'h608, 12'h682, 12'h68C,
        12'h6C0, 12'h704, 12'h74A, 12'h74C, 12'h75A, 12'h75E
    };
    // Slots of the operating state code, the speed and the bus current readbacks
    localparam logic [NREG-1:0] REG_NARROW = 36'h0_0000_00C1;
    localparam int SLOT_STATE = 0;
    localparam int SLOT_SPEED = 1;
    localparam int SLOT_BUS_CURRENT = 2;
    localparam logic [DW-1:0] VAL_RESET = 32'h0000_0000;

    // Control and status registers of the bank itself
    localparam logic [IDXW-1:0] IDX_CTRL = 12'h7F0;
    localparam logic [IDXW-1:0] IDX_STAT = 12'h7F2;
    localparam int CTRL_ROERR_BIT = 0;
    localparam int STAT_CNT_W = 16;
    localparam int STAT_ROERR_BIT = 16;
    localparam int STAT_FAULT_BIT = 17;
    localparam int STAT_MEAS_BIT = 18;
    localparam int STAT_IDLE_BIT = 19;
    localparam int STAT_LANE = 2;

    // Operating state codes
    localparam logic [15:0] ST_IDLE = 16'h0000;
    localparam logic [15:0] ST_INITIAL_SPEED_DETECTION = 16'h0001;
    localparam logic [15:0] ST_OUTPUTS_FLOATING = 16'h0002;
    localparam logic [15:0] ST_ALIGN = 16'h0006;
    localparam logic [15:0] ST_OPEN_LOOP = 16'h0007;
    localparam logic [15:0] ST_FAULT = 16'h000E;
    localparam logic [15:0] ST_PARAMETER_MEASUREMENT_FIRST = 16'h0010;
    localparam logic [15:0] ST_PARAMETER_MEASUREMENT_LAST = 16'h0017;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } mav_wr_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } mav_rd_t;
endpackage : mav_pkg

// ===== design/mav_readback.sv
// Algorithm variable readback bank with an AXI4-Lite slave port
//
// Functional notes
// - State code at 190h, commutation speed at 196h, bus current at 410h.
// - State code is read-only, 16 bits, resets to zero, documented codes.
// - Speed feedback is read-only unsigned 32 bits, fraction of top speed times 2^27.
// - Bus current is read-only signed 32 bits, two's complement.
// - Amperes equal value over 2^27 times base current over 8.
//
// Chosen here: the AXI4-Lite slave port.
module mav_readback (
    // Clock, reset and enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Write address channel
    input wire logic [mav_pkg::AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [mav_pkg::DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [mav_pkg::AW-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [mav_pkg::DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Values computed by the control algorithm
    input wire logic upd_valid,
    input wire logic [mav_pkg::IDXW-1:0] upd_index,
    input wire logic [mav_pkg::DW-1:0] upd_data
);

    typedef struct packed {
        mav_pkg::mav_wr_t wr;
        mav_pkg::mav_rd_t rd;
        logic aw_got;
        logic w_got;
        logic aw_bad;
        logic [mav_pkg::IDXW-1:0] aw_idx;
        logic [mav_pkg::DW-1:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [mav_pkg::DW-1:0] rdata;
        logic ro_err_en;
        logic ro_err_flag;
        logic [mav_pkg::STAT_CNT_W-1:0] upd_cnt;
        logic [mav_pkg::NREG-1:0][mav_pkg::DW-1:0] vals;
    } mav_state_t;

    localparam mav_state_t STATE_RESET = '{
        wr: mav_pkg::WR_COLLECT,
        rd: mav_pkg::RD_IDLE,
        aw_idx: '0,
        wdata: '0,
        wstrb: '0,
        bresp: mav_pkg::RESP_OKAY,
        rresp: mav_pkg::RESP_OKAY,
        rdata: '0,
        upd_cnt: '0,
        vals: {mav_pkg::NREG{mav_pkg::VAL_RESET}},
        default: 1'b0
    };

    mav_state_t s_r;
    mav_state_t s_nxt;

    // Per-entry address matches and the value each entry would read
    logic [mav_pkg::NREG-1:0] upd_hit;
    logic [mav_pkg::NREG-1:0] rd_hit;
    logic [mav_pkg::NREG-1:0] wr_hit;
    logic [mav_pkg::NREG-1:0][mav_pkg::DW-1:0] cur_val;
    logic [mav_pkg::NREG-1:0][mav_pkg::DW-1:0] new_val;

    logic [mav_pkg::IDXW-1:0] ar_idx;
    logic [mav_pkg::IDXW-1:0] aw_idx_in;
    logic ar_bad;
    logic aw_bad_in;

    assign ar_idx = araddr[mav_pkg::IDX_MSB:mav_pkg::IDX_LSB];
    assign aw_idx_in = awaddr[mav_pkg::IDX_MSB:mav_pkg::IDX_LSB];
    // Upper bits and the byte offset inside a word must be zero
    assign ar_bad = (araddr[mav_pkg::AW-1:mav_pkg::IDX_MSB+1] != '0)
                    || (araddr[mav_pkg::IDX_LSB-1:0] != '0);
    assign aw_bad_in = (awaddr[mav_pkg::AW-1:mav_pkg::IDX_MSB+1] != '0)
                       || (awaddr[mav_pkg::IDX_LSB-1:0] != '0);

    genvar gi;
    generate
        for (gi = 0; gi < mav_pkg::NREG; gi++) begin : g_entry
            assign upd_hit[gi] = upd_valid
                                 && (upd_index == mav_pkg::REG_IDX[gi]);
            assign rd_hit[gi] = !ar_bad && (ar_idx == mav_pkg::REG_IDX[gi]);
            assign wr_hit[gi] = s_r.aw_idx == mav_pkg::REG_IDX[gi];
            // Narrow registers keep only the low half; upper bits read zero
            assign new_val[gi] = mav_pkg::REG_NARROW[gi]
                ? {{(mav_pkg::DW-mav_pkg::NARROW_W){1'b0}},
                   upd_data[mav_pkg::NARROW_W-1:0]}
                : upd_data;
            // A read that meets an update in the same cycle sees the update
            assign cur_val[gi] = upd_hit[gi] ? new_val[gi] : s_r.vals[gi];
        end
    endgenerate

    // Decoded view of the stored operating state code
    logic [15:0] state_code;
    logic st_fault;
    logic st_meas;
    logic st_idle;

    assign state_code =
        s_r.vals[mav_pkg::SLOT_STATE][mav_pkg::NARROW_W-1:0];
    assign st_fault = state_code == mav_pkg::ST_FAULT;
    assign st_idle = state_code == mav_pkg::ST_IDLE;
    assign st_meas = (state_code >= mav_pkg::ST_PARAMETER_MEASUREMENT_FIRST)
                     && (state_code <= mav_pkg::ST_PARAMETER_MEASUREMENT_LAST);

    logic [mav_pkg::DW-1:0] stat_word;
    logic [mav_pkg::DW-1:0] ctrl_word;

    always_comb begin
        stat_word = '0;
        stat_word[mav_pkg::STAT_CNT_W-1:0] = s_r.upd_cnt;
        stat_word[mav_pkg::STAT_ROERR_BIT] = s_r.ro_err_flag;
        stat_word[mav_pkg::STAT_FAULT_BIT] = st_fault;
        stat_word[mav_pkg::STAT_MEAS_BIT] = st_meas;
        stat_word[mav_pkg::STAT_IDLE_BIT] = st_idle;
        ctrl_word = '0;
        ctrl_word[mav_pkg::CTRL_ROERR_BIT] = s_r.ro_err_en;
    end

    always_comb begin
        logic rd_mapped;
        logic wr_mapped;
        logic aw_take;
        logic w_take;
        logic err_set;
        logic err_clr;
        logic [mav_pkg::DW-1:0] rd_word;
        logic [1:0] rd_resp;

        rd_mapped = 1'b0;
        wr_mapped = 1'b0;
        aw_take = 1'b0;
        w_take = 1'b0;
        err_set = 1'b0;
        err_clr = 1'b0;
        rd_word = '0;
        rd_resp = mav_pkg::RESP_DECERR;
        s_nxt = s_r;

        // Values from the algorithm land in their slot on the next edge
        for (int i = 0; i < mav_pkg::NREG; i++) begin
            if (upd_hit[i]) begin
                s_nxt.vals[i] = new_val[i];
            end
        end
        if (|upd_hit) begin
            s_nxt.upd_cnt = s_r.upd_cnt + 1'b1;
        end

        // Read path: one read in flight, answered the cycle after it is taken
        for (int i = 0; i < mav_pkg::NREG; i++) begin
            if (rd_hit[i]) begin
                rd_mapped = 1'b1;
                rd_word = cur_val[i];
            end
        end
        if (!ar_bad && ar_idx == mav_pkg::IDX_CTRL) begin
            rd_mapped = 1'b1;
            rd_word = ctrl_word;
        end
        if (!ar_bad && ar_idx == mav_pkg::IDX_STAT) begin
            rd_mapped = 1'b1;
            rd_word = stat_word;
        end
        if (rd_mapped) begin
            rd_resp = mav_pkg::RESP_OKAY;
        end else begin
            rd_word = '0;
        end

        case (s_r.rd)
            mav_pkg::RD_IDLE: begin
                if (s_r.arready && arvalid) begin
                    s_nxt.rdata = rd_word;
                    s_nxt.rresp = rd_resp;
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rd = mav_pkg::RD_RESP;
                end
            end
            mav_pkg::RD_RESP: begin
                if (rready) begin
                    s_nxt.rvalid = 1'b0;
                    s_nxt.rd = mav_pkg::RD_IDLE;
                end
            end
            default: begin
                s_nxt.rvalid = 1'b0;
                s_nxt.rd = mav_pkg::RD_IDLE;
            end
        endcase
        s_nxt.arready = s_nxt.rd == mav_pkg::RD_IDLE;

        // Write path: address and data are collected in either order
        for (int i = 0; i < mav_pkg::NREG; i++) begin
            if (wr_hit[i]) begin
                wr_mapped = 1'b1;
            end
        end

        case (s_r.wr)
            mav_pkg::WR_COLLECT: begin
                aw_take = s_r.awready && awvalid;
                w_take = s_r.wready && wvalid;
                if (aw_take) begin
                    s_nxt.aw_got = 1'b1;
                    s_nxt.aw_idx = aw_idx_in;
                    s_nxt.aw_bad = aw_bad_in;
                end
                if (w_take) begin
                    s_nxt.w_got = 1'b1;
                    s_nxt.wdata = wdata;
                    s_nxt.wstrb = wstrb;
                end
                if (s_r.aw_got && s_r.w_got) begin
                    s_nxt.aw_got = 1'b0;
                    s_nxt.w_got = 1'b0;
                    s_nxt.bvalid = 1'b1;
                    s_nxt.wr = mav_pkg::WR_RESP;
                    if (s_r.aw_bad) begin
                        s_nxt.bresp = mav_pkg::RESP_DECERR;
                        err_set = 1'b1;
                    end else if (s_r.aw_idx == mav_pkg::IDX_CTRL) begin
                        s_nxt.bresp = mav_pkg::RESP_OKAY;
                        if (s_r.wstrb[0]) begin
                            s_nxt.ro_err_en =
                                s_r.wdata[mav_pkg::CTRL_ROERR_BIT];
                        end
                    end else if (s_r.aw_idx == mav_pkg::IDX_STAT) begin
                        s_nxt.bresp = mav_pkg::RESP_OKAY;
                        err_clr = s_r.wstrb[mav_pkg::STAT_LANE]
                                  && s_r.wdata[mav_pkg::STAT_ROERR_BIT];
                    end else if (wr_mapped) begin
                        // Monitored values never change from the bus
                        s_nxt.bresp = s_r.ro_err_en
                                      ? mav_pkg::RESP_SLVERR
                                      : mav_pkg::RESP_OKAY;
                        err_set = 1'b1;
                    end else begin
                        s_nxt.bresp = mav_pkg::RESP_DECERR;
                        err_set = 1'b1;
                    end
                end
            end
            mav_pkg::WR_RESP: begin
                if (bready) begin
                    s_nxt.bvalid = 1'b0;
                    s_nxt.wr = mav_pkg::WR_COLLECT;
                end
            end
            default: begin
                s_nxt.bvalid = 1'b0;
                s_nxt.aw_got = 1'b0;
                s_nxt.w_got = 1'b0;
                s_nxt.wr = mav_pkg::WR_COLLECT;
            end
        endcase
        // Each ready drops once its own half is held so a second write cannot overtake
        s_nxt.awready = (s_nxt.wr == mav_pkg::WR_COLLECT) && !s_nxt.aw_got
                        && !(s_r.aw_got && s_r.w_got);
        s_nxt.wready = (s_nxt.wr == mav_pkg::WR_COLLECT) && !s_nxt.w_got
                       && !(s_r.aw_got && s_r.w_got);

        // Sticky refused-write flag; a new refusal beats a clear
        if (err_set) begin
            s_nxt.ro_err_flag = 1'b1;
        end else if (err_clr) begin
            s_nxt.ro_err_flag = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= STATE_RESET;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = s_r.rdata;

endmodule : mav_readback

// ===== test/mav_readback_props.sv
// Checker of the readback bank's bus and update behaviour
module mav_readback_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [mav_pkg::AW-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [mav_pkg::DW-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // Algorithm updates
    input wire logic upd_valid,
    input wire logic [mav_pkg::IDXW-1:0] upd_index,
    input wire logic [mav_pkg::DW-1:0] upd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [mav_pkg::AW-1:0] addr_r;
    logic [mav_pkg::DW-1:0] speed_r;
    logic [mav_pkg::DW-1:0] exp_r;
    logic hit;
    logic at_state;
    logic at_speed;
    logic at_bus;
    // Same-edge update wins over the stored speed
    assign hit = upd_valid && upd_index == 12'h196;
    assign at_state = addr_r == 16'h0640;
    assign at_speed = addr_r == 16'h0658;
    assign at_bus = addr_r == 16'h1040;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= '0;
            speed_r <= '0;
            exp_r <= '0;
        end else begin
            if (hit)
                speed_r <= upd_data;
            if (arvalid && arready) begin
                addr_r <= araddr;
                exp_r <= hit ? upd_data : speed_r;
            end
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence resp_due;
        ##2 bvalid;
    endsequence
    chk_write_latency: assert property (both_taken |-> resp_due)
        else $error("write response not on time");
    chk_read_latency: assert property (arvalid && arready |=> rvalid)
        else $error("read data not on time");
    property p_read_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_state_upper;
        rvalid && at_state |-> rdata[31:16] == 16'h0000;
    endproperty
    property p_map_okay;
        rvalid && (at_state || at_speed || at_bus)
            |-> rresp == mav_pkg::RESP_OKAY;
    endproperty
    property p_speed_latest;
        rvalid && at_speed |-> rdata == exp_r;
    endproperty
    chk_read_hold: assert property (p_read_hold)
        else $error("read data dropped");
    chk_b_hold: assert property (p_b_hold)
        else $error("write response changed");
    chk_ar_blocked: assert property (rvalid |-> !arready)
        else $error("second read open");
    chk_state_upper: assert property (p_state_upper)
        else $error("state code upper half set");
    chk_map_okay: assert property (p_map_okay)
        else $error("listed register refused");
    chk_speed_latest: assert property (p_speed_latest)
        else $error("speed value stale");
    chk_reset_quiet: assert property ($rose(aresetn) |-> !rvalid && !bvalid)
        else $error("response after reset");
endmodule : mav_readback_props

// ===== test/mav_host.sv
// Host model speaking AXI4-Lite to the readback bank
module mav_host (
    // Clock
    input wire logic aclk,
    // Cycles to wait before offering a response ready
    input wire logic [1:0] rsp_wait,
    // Write channels
    output logic [mav_pkg::AW-1:0] awaddr,
    output logic [2:0] awprot,
    output logic awvalid,
    input wire logic awready,
    output logic [mav_pkg::DW-1:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [mav_pkg::AW-1:0] araddr,
    output logic [2:0] arprot,
    output logic arvalid,
    input wire logic arready,
    input wire logic [mav_pkg::DW-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Late response readies make the slave hold its answer
    initial begin
        {awaddr, awprot, awvalid, wdata, wstrb, wvalid} = '0;
        {araddr, arprot, arvalid} = '0;
        bready = 1'b0;
        rready = 1'b0;
    end
    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        repeat (rsp_wait) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // Writes reserved or read-only places to test refusal, and the control and status words
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_go;
        logic w_go;
        aw_go = 1'b1;
        w_go = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_go || w_go) begin
            @(posedge aclk);
            if (aw_go && awready) begin
                aw_go = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (w_go && wready) begin
                w_go = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        repeat (rsp_wait) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
endmodule : mav_host

// ===== test/testbench.sv
// Self-checking bench of the readback bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, upd_valid;
    logic [11:0] upd_index;
    logic [31:0] upd_data, wdata, rdata, seed, d;
    logic [15:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [1:0] rsp_wait;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int failures, tests_run;
    localparam logic [11:0] IDX3 [3] = '{12'h190, 12'h196, 12'h410};
    localparam logic [15:0] CODES [14] = '{16'h0000, 16'h0001, 16'h0002,
        16'h0006, 16'h0007, 16'h000E, 16'h0010, 16'h0011, 16'h0012,
        16'h0013, 16'h0014, 16'h0015, 16'h0016, 16'h0017};
    mav_readback mav_readback_inst (.aclk(aclk), .aresetn(aresetn),
        .clk_en(1'b1), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .upd_valid(upd_valid), .upd_index(upd_index), .upd_data(upd_data));
    mav_host mav_host_inst (.aclk(aclk), .rsp_wait(rsp_wait),
        .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // The state code register at 190h reads its upper half as zero
    function automatic logic [31:0] exp_rd(input logic [11:0] i,
                                           input logic [31:0] v);
        return (i == 12'h190) ? {16'h0000, v[15:0]} : v;
    endfunction : exp_rd
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t data %h expected %h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t resp %h expected %h", $time, g, e);
        end
    endtask : chk_resp
    task automatic rdchk(input logic [11:0] i, input logic [31:0] e,
                         input logic [1:0] er);
        mav_host_inst.rd({2'b00, i, 2'b00}, d, r);
        chk_word(d, e);
        chk_resp(r, er);
    endtask : rdchk
    task automatic upd(input logic [11:0] i, input logic [31:0] v);
        upd_valid <= 1'b1;
        upd_index <= i;
        upd_data <= v;
        @(posedge aclk);
        upd_valid <= 1'b0;
    endtask : upd
    task automatic complete_run();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        $display("BAD %0t run hung", $time);
        complete_run();
    end
    initial begin
        {aresetn, upd_valid, upd_index, upd_data, rsp_wait} = '0;
        {failures, tests_run} = '0;
        seed = 32'h0000_000C;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 3; k++)
            rdchk(IDX3[k], 32'h0000_0000, mav_pkg::RESP_OKAY);
        // Longest response stall on the writes to the three read-only registers
        rsp_wait <= 2'h3;
        for (int k = 0; k < 3; k++) begin
            mav_host_inst.wr({2'b00, IDX3[k], 2'b00}, 32'hFFFF_FFFF, r);
            chk_resp(r, mav_pkg::RESP_OKAY);
            rdchk(IDX3[k], 32'h0000_0000, mav_pkg::RESP_OKAY);
        end
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            rsp_wait <= seed[1:0];
            upd(IDX3[k % 3], seed);
            rdchk(IDX3[k % 3], exp_rd(IDX3[k % 3], seed), 2'h0);
        end
        foreach (CODES[k]) begin
            upd(12'h190, {16'hFFFF, CODES[k]});
            rdchk(12'h190, {16'h0000, CODES[k]}, 2'h0);
        end
        // Minus one eighth of the base current
        upd(12'h410, 32'hF800_0000);
        rdchk(12'h410, 32'hF800_0000, mav_pkg::RESP_OKAY);
        upd(12'h191, 32'h1234_5678);
        rdchk(12'h191, 32'h0000_0000, mav_pkg::RESP_DECERR);
        mav_host_inst.wr(16'h0641, 32'h0000_0003, r);
        chk_resp(r, mav_pkg::RESP_DECERR);
        rdchk(12'h190, 32'h0000_0017, mav_pkg::RESP_OKAY);
        // Error-answer mode, then the status word after 27 updates
        mav_host_inst.wr(16'h1FC0, 32'h0000_0001, r);
        chk_resp(r, mav_pkg::RESP_OKAY);
        rdchk(12'h7F0, 32'h0000_0001, mav_pkg::RESP_OKAY);
        mav_host_inst.wr(16'h1040, 32'h0000_1234, r);
        chk_resp(r, mav_pkg::RESP_SLVERR);
        rdchk(12'h410, 32'hF800_0000, mav_pkg::RESP_OKAY);
        rdchk(12'h7F2, 32'h0005_001B, mav_pkg::RESP_OKAY);
        mav_host_inst.wr(16'h1FC8, 32'h0001_0000, r);
        chk_resp(r, mav_pkg::RESP_OKAY);
        rdchk(12'h7F2, 32'h0004_001B, mav_pkg::RESP_OKAY);
        upd(12'h190, 32'h0000_000E);
        rdchk(12'h7F2, 32'h0002_001C, mav_pkg::RESP_OKAY);
        upd(12'h190, 32'h0000_0000);
        rdchk(12'h7F2, 32'h0008_001D, mav_pkg::RESP_OKAY);
        complete_run();
    end
endmodule : testbench
bind mav_readback mav_readback_props mav_readback_props_inst (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .upd_valid(upd_valid), .upd_index(upd_index),
    .upd_data(upd_data));
